/* File: rtl/crf_defs.vh */
// crf_defs.vh: constants for the capture record formatter
// assumes: included by bare name from rtl design files
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH
`define CRF_VAR_HDLC      7'h01
`define CRF_VAR_ATM       7'h03
`define CRF_VAR_AAL5      7'h04
`define CRF_VAR_MCHDLC    7'h05
`define CRF_EXT_BIT       7
`define CRF_FIXED_HDR     16'h0010
`define CRF_PROTO_HDR     16'h0004
`define CRF_EXT_WORD      16'h0008
`define CRF_CELL_PAY      16'h0030
`define CRF_ATM_RLEN      16'h0045
`define CRF_FLAG_VLEN     2
`define CRF_FLAG_RXERR    4
`define CRF_FIFO_DEPTH    8
`define CRF_HDR_BYTES     20
`define CRF_HDR_LAST      5'h13
`endif

/* File: rtl/crf_fifo.v */
// crf_fifo.v: small synchronous byte fifo, flip-flop storage
// assumes: single clock CLK, synchronous active-high reset
`timescale 1ns/10ps
module crf_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // honest full/empty from the occupancy count
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers and count
  always @(posedge clk) begin
    if (rst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // storage, no reset needed on data
  always @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule // crf_fifo

/* File: rtl/crf_formatter.v */
// crf_formatter.v: builds capture records from received frames and cells
// assumes: same-clock upstream giving header info at start, then payload bytes;
// downstream host stream buffer drains a byte stream with valid/ready.
//
// Overview of operation
// - type byte bit 7 marks extension headers; low seven bits give variant
// - packet-over-sonet hdlc frames produce records of variant 1
// - hdlc record: 4-byte protocol header right after the fixed header, before extension words
// - single atm cells produce records of variant 3
// - atm record carries 4-byte cell header without the check octet
// - atm records keep the variable-length flag cleared
// - atm payload is 48 cell bytes then the check byte
// - reassembled aal5 frames produce records of variant 4
// - aal5 record stores only the first cell header, no check octet
// - aal5 payload holds all cell contents including padding and trailer
// - receive-error flag set when aal5 crc check fails
// - aal5 payload length is record length minus 16, extensions, and 4
// - channelized hdlc frames produce records of variant 5
// - record length is total bytes; next record starts that far on
// - 16-bit loss counter counts records dropped since previous record
// - type bit 7 cleared when no extension headers follow
`timescale 1ns/10ps
`include "crf_defs.vh"
module crf_formatter (
  input  wire        CLK,
  input  wire        RST,
  input  wire        START,
  input  wire [1:0]  KIND,
  input  wire [63:0] TSTAMP,
  input  wire [7:0]  IFLAGS,
  input  wire [15:0] WLEN,
  input  wire [15:0] PAY_LEN,
  input  wire [31:0] PROTO_HDR,
  input  wire [7:0]  EXT_WORDS,
  input  wire        CRC_FAIL,
  output wire        START_READY,
  input  wire [7:0]  PAY_DATA,
  input  wire        PAY_VALID,
  output wire        PAY_READY,
  output wire [7:0]  OUT_DATA,
  output wire        OUT_LAST,
  output wire        OUT_VALID,
  input  wire        OUT_READY,
  output wire        DROP
);
  // kind codes on KIND
  localparam K_POS   = 2'h0;
  localparam K_ATM   = 2'h1;
  localparam K_AAL5  = 2'h2;
  localparam K_MC    = 2'h3;
  // states
  localparam S_IDLE  = 2'h0;
  localparam S_HDR   = 2'h1;
  localparam S_PAY   = 2'h2;

  reg  [1:0]   state_q, state_d;
  reg  [7:0]   hmem_q [0:`CRF_HDR_BYTES-1];
  reg  [4:0]   hcnt_q;
  reg  [4:0]   hlen_q;
  reg  [15:0]  pcnt_q;
  reg  [15:0]  loss_q;
  reg  [6:0]   var_d;
  reg  [7:0]   flags_d;
  reg  [15:0]  rlen_d;
  reg  [15:0]  plen_d;
  wire [7:0]   typ_d;
  wire         f_ready;
  wire         f_valid;
  reg  [8:0]   f_data;
  wire [15:0]  ext_bytes;
  wire [159:0] hdr_w;
  wire         take;
  wire         hdr_end;
  wire         pay_none;
  genvar       gi;

  // variant selection per incoming kind
  always @* begin
    case (KIND)
      K_POS:   var_d = `CRF_VAR_HDLC;
      K_ATM:   var_d = `CRF_VAR_ATM;
      K_AAL5:  var_d = `CRF_VAR_AAL5;
      K_MC:    var_d = `CRF_VAR_MCHDLC;
      default: var_d = `CRF_VAR_HDLC;
    endcase
  end

  // bit 7 only when extension words follow, keeping old readers happy
  assign typ_d = {(EXT_WORDS != 8'h00), var_d};
  assign ext_bytes = {5'h00, EXT_WORDS, 3'h0};

  // fixed header then protocol header, big-endian, in the order they leave
  assign hdr_w[159:96] = TSTAMP;
  assign hdr_w[95:88]  = typ_d;
  assign hdr_w[87:80]  = flags_d;
  assign hdr_w[79:64]  = rlen_d;
  assign hdr_w[63:48]  = loss_q;    // drops since the last record
  assign hdr_w[47:32]  = WLEN;
  assign hdr_w[31:0]   = PROTO_HDR; // first cell header only

  // header store, one entry per byte, loaded in parallel when a start is taken
  generate
    for (gi = 0; gi < `CRF_HDR_BYTES; gi = gi + 1) begin : g_hdr
      always @(posedge CLK) begin
        if (take)
          hmem_q[gi] <= hdr_w[159-8*gi -: 8]; // entry 0 is the timestamp msb
      end
    end
  endgenerate

  // flags and lengths; atm cells have a fixed size regardless of PAY_LEN
  always @* begin
    flags_d = IFLAGS;
    plen_d  = PAY_LEN;
    if (KIND == K_ATM) begin
      flags_d[`CRF_FLAG_VLEN] = 1'b0;
      plen_d = `CRF_CELL_PAY + 16'h0001;
    end
    if (KIND == K_AAL5)
      flags_d[`CRF_FLAG_RXERR] = IFLAGS[`CRF_FLAG_RXERR] | CRC_FAIL;
    // payload = rlen - fixed - ext - proto, so rlen is their sum
    rlen_d = plen_d + `CRF_FIXED_HDR + ext_bytes + `CRF_PROTO_HDR;
  end

  // a start is taken only when idle; a start offered while busy is lost
  assign START_READY = (state_q == S_IDLE);
  assign DROP        = START & (state_q != S_IDLE);

  // handshake terms shared by the state machine and the counters
  assign take     = (state_q == S_IDLE) & START;
  assign pay_none = (pcnt_q == 16'h0000);
  assign hdr_end  = (state_q == S_HDR) & f_ready & (hcnt_q == hlen_q);

  // byte source toward the fifo: stored header by index, then payload
  assign PAY_READY = (state_q == S_PAY) & f_ready;
  assign f_valid   = (state_q == S_HDR) | ((state_q == S_PAY) & PAY_VALID);
  always @* begin
    // a record with nothing after the header ends on its last header byte
    f_data = {(hcnt_q == hlen_q) & pay_none, hmem_q[hcnt_q]};
    if (state_q == S_PAY)
      f_data = {(pcnt_q == 16'h0001), PAY_DATA};
  end

  // next state
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (START) state_d = S_HDR;
      S_HDR:  if (hdr_end) state_d = pay_none ? S_IDLE : S_PAY; // no hang on an empty payload
      S_PAY:  if (f_ready && PAY_VALID && pcnt_q == 16'h0001) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // header assembly and counters
  always @(posedge CLK) begin
    if (RST) begin
      state_q <= S_IDLE;
      hcnt_q  <= 5'h00;
      hlen_q  <= 5'h00;
      pcnt_q  <= 16'h0000;
      loss_q  <= 16'h0000;
    end else begin
      state_q <= state_d;
      // drops counted with saturation, reported and cleared in the next record
      if (DROP && loss_q != 16'hFFFF)
        loss_q <= loss_q + 16'h0001;
      if (take) begin
        // extension words themselves come in with the payload stream
        hlen_q <= `CRF_HDR_LAST;       // 16 fixed + 4 protocol bytes, minus 1
        hcnt_q <= 5'h00;
        pcnt_q <= plen_d + ext_bytes;
        loss_q <= {15'h0000, DROP};
      end else if (state_q == S_HDR && f_ready && hcnt_q != hlen_q) begin
        // index stops on the last entry so the byte source never leaves the store
        hcnt_q <= hcnt_q + 5'h01;
      end else if (state_q == S_PAY && f_ready && PAY_VALID) begin
        pcnt_q <= pcnt_q - 16'h0001;
      end
    end
  end

  // output buffer toward the host stream, back-pressure reaches PAY_READY
  crf_fifo #(
    .WIDTH (9),
    .DEPTH (`CRF_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_data   (f_data),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .out_data  ({OUT_LAST, OUT_DATA}),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY)
  );
endmodule // crf_formatter

/* File: dv/crf_monitor.sv */
// crf_monitor: record stream checks on formatter ports
// assumes: bound to crf_formatter, single clock
`timescale 1ns/10ps
module crf_monitor (
  input wire       CLK,
  input wire       RST,
  input wire       START,
  input wire       START_READY,
  input wire       DROP,
  input wire       OUT_VALID,
  input wire       OUT_READY,
  input wire       OUT_LAST,
  input wire [7:0] OUT_DATA,
  input wire [7:0] EXT_WORDS
);
  logic [15:0] n_q, rl_q;
  logic [15:0] dc_q, lc_q;
  logic [7:0] ty_q, ex_q;
  wire hs = OUT_VALID && OUT_READY;
  wire at8 = hs && n_q == 16'h8;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_stall; OUT_VALID && !OUT_READY; endsequence
  // byte index, type and length of the record leaving
  always @(posedge CLK) begin
    if (RST) begin
      n_q <= 16'h0;
      ex_q <= 8'h0;
      dc_q <= 16'h0;
      lc_q <= 16'h0;
    end else begin
      // drops seen since the last taken start, handed to the next record taken
      if (START && START_READY) begin
        ex_q <= EXT_WORDS;
        lc_q <= dc_q;
        dc_q <= 16'h0;
      end else if (DROP && dc_q != 16'hFFFF) begin
        dc_q <= dc_q + 16'h1;
      end
      if (hs) n_q <= OUT_LAST ? 16'h0 : n_q + 16'h1;
      if (at8) ty_q <= OUT_DATA;
      if (hs && n_q[15:1] == 15'h5) rl_q <= {rl_q[7:0], OUT_DATA}; // both length bytes
    end
  end
  a_type_code: assert property (at8 |-> OUT_DATA[6:0] inside {7'h1, 7'h3, 7'h4, 7'h5})
    else $error("variant");
  a_ext_flag: assert property (at8 |-> OUT_DATA[7] == (ex_q != 8'h0))
    else $error("ext bit");
  a_atm_fixed: assert property (hs && n_q == 16'h9 && ty_q == 8'h3 |-> !OUT_DATA[2])
    else $error("atm vlen");
  a_rlen_total: assert property (hs && OUT_LAST |-> n_q + 16'h1 == rl_q)
    else $error("rlen");
  a_atm_size: assert property (hs && OUT_LAST && ty_q == 8'h3 |-> n_q == 16'h44)
    else $error("atm size");
  a_loss_count: assert property (hs && n_q == 16'hD |-> OUT_DATA == lc_q[7:0])
    else $error("loss count");
  a_drop_busy: assert property (DROP |-> START && !START_READY)
    else $error("drop");
  a_byte_held: assert property (s_stall |=> OUT_VALID && $stable(OUT_DATA))
    else $error("held");
  a_start_answer: assert property (START && START_READY |-> ##[1:60] OUT_VALID)
    else $error("answer");
endmodule // crf_monitor

/* File: dv/crf_sink.sv */
// crf_sink: host stream buffer model, keeps every byte
// assumes: formatter clock; stalls one cycle in four
`timescale 1ns/10ps
module crf_sink (
  input  wire       clk,
  input  wire       valid,
  input  wire       last,
  input  wire [7:0] data,
  output wire       ready
);
  logic [7:0] mem [0:2047];
  logic [1:0] ph_q = 2'h0;
  int n = 0, recs = 0;
  assign ready = ph_q != 2'h0; // stalls let the fifo fill
  // store accepted bytes in order
  always @(posedge clk) begin
    ph_q <= ph_q + 2'h1;
    if (valid && ready) begin
      mem[n] <= data;
      n <= n + 1;
      recs <= recs + last;
    end
  end
endmodule // crf_sink

/* File: dv/testbench.sv */
// testbench: record rows, then a lost start
// assumes: crf_sink drains, crf_monitor bound
`timescale 1ns/10ps
module testbench;
  logic CLK = 0, RST = 1, START = 0, PAY_VALID = 0, CRC_FAIL = 0;
  logic [1:0] KIND = 0;
  logic [7:0] EXT_WORDS = 0, PAY_DATA = 0;
  logic [15:0] PAY_LEN = 0;
  wire [7:0] OUT_DATA;
  wire START_READY, PAY_READY, OUT_LAST, OUT_VALID, OUT_READY, DROP;
  int failures = 0, num_checks = 0, b;
  // kind, ext, payload, crc fail, type byte, length
  int rows[4][6] = '{'{0,0,5,0,1,25}, '{1,0,49,0,3,69}, '{2,1,56,1,132,84}, '{3,0,3,0,5,23}};
  crf_formatter dut (.CLK, .RST, .START, .KIND, .TSTAMP(64'h0123456789ABCDEF), .IFLAGS(8'h04), .WLEN(16'h40),
    .PAY_LEN, .PROTO_HDR(32'hA1B2C3D4), .EXT_WORDS, .CRC_FAIL, .START_READY, .PAY_DATA, .PAY_VALID, .PAY_READY,
    .OUT_DATA, .OUT_LAST, .OUT_VALID, .OUT_READY, .DROP);
  crf_sink snk (.clk(CLK), .valid(OUT_VALID), .last(OUT_LAST), .data(OUT_DATA), .ready(OUT_READY));
  always #10 CLK = ~CLK;
  task chk(logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for ready, then the taking edge
  task automatic go(bit p, int t = 0);
    #1;
    while ((p ? PAY_READY : START_READY) !== 1'b1) begin
      if (++t > 900) begin failures++; results; end
      @(negedge CLK) #1;
    end
    @(posedge CLK);
  endtask
  // one record; d raises a start while busy
  task automatic send(int k, e, p, c, d, int t = 0);
    int r = snk.recs;
    b = snk.n;
    @(negedge CLK) {KIND, EXT_WORDS, PAY_LEN, CRC_FAIL, START} = {k[1:0], e[7:0], p[15:0], c[0], 1'b1};
    go(0);
    @(negedge CLK) START = d[0];
    #1 if (d) chk(DROP, 1);
    for (int j = 0; j < e * 8 + p; j++) begin
      @(negedge CLK) {START, PAY_VALID, PAY_DATA} = {2'b01, j[7:0]};
      go(1);
    end
    @(negedge CLK) PAY_VALID = 0;
    while (snk.recs == r) begin
      if (++t > 3000) begin failures++; results; end
      @(negedge CLK);
    end
  endtask
  initial begin
    repeat (6) @(negedge CLK);
    chk({OUT_VALID, START_READY, PAY_READY}, 3'b010);
    RST = 0;
    foreach (rows[n]) begin
      send(rows[n][0], rows[n][1], rows[n][2], rows[n][3], 0);
      chk(snk.mem[b+8], rows[n][4]);
      chk({snk.mem[b+10], snk.mem[b+11]}, rows[n][5]);
      chk(snk.n - b, rows[n][5]);
      chk(snk.mem[b+9] & 8'h14, {rows[n][3][0], 1'b0, rows[n][0] != 1, 2'b0});
      chk({snk.mem[b+16], snk.mem[b+19]}, 16'hA1D4);
      chk({snk.mem[b], snk.mem[b+7]}, 16'h01EF);
      chk({snk.mem[b+14], snk.mem[b+15]}, 16'h0040);
      chk(snk.mem[snk.n-1], rows[n][1] * 8 + rows[n][2] - 1);
    end
    // lost start is reported by the next record
    send(1, 0, 49, 0, 1);
    chk({snk.mem[b+12], snk.mem[b+13]}, 0);
    send(2, 2, 1, 0, 0);
    chk({snk.mem[b+12], snk.mem[b+13]}, 1);
    chk(snk.mem[b+8], 8'h84);
    // header-only record still ends and reports its own length
    send(0, 0, 0, 0, 0);
    chk(snk.n - b, 20);
    chk({snk.mem[b+10], snk.mem[b+11]}, 20);
    chk(snk.mem[snk.n-1], 8'hD4);
    results;
  end
endmodule // testbench
bind crf_formatter crf_monitor mon (.CLK, .RST, .START, .START_READY, .DROP, .OUT_VALID, .OUT_READY,
  .OUT_LAST, .OUT_DATA, .EXT_WORDS);
